// [verilog/io_timer_decode_and_irq.sv]
`timescale 1ns/1ps
// Contract
// R1 - Timer access clears timer flag after timeout
// R2 - Read coinciding with timeout keeps flag set
// R3 - Post-timeout count reads as negative elapsed periods
// R4 - Software reads timer after interrupt with IRQ off
// R5 - Flag register holds timer and edge flags
// R6 - Flag read clears edge flag only
// R7 - RAM selected by chip selects, ram select low
// R8 - I/O section selected with ram select high
// R9 - Address bit 2 picks timer or ports
// R10 - Bits 1:0 pick one of four port registers
// R11 - Timer write loads count and prescale
// R12 - Timer access bit 3 sets timer IRQ enable
// R13 - Read with bits 2,0 high returns flags
// R14 - Edge sets bit 6, may pull IRQ
// R15 - Edge config write: enable and polarity bits
// R16 - Edge flag set regardless of pin direction
// R17 - Reset disables edge IRQ, selects falling edge
// R18 - Software clears stale edge flag after reset
// R19 - Timeout sets bit 7 regardless of enable
// R20 - After timeout count drops every clock
// R21 - Interrupt output active low, open drain
// R22 - Direction bit 1 output, 0 input
module io_timer_decode_and_irq
	import io_timer_pkg::*;
(
	// Clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_n,
	// Processor bus
	input  wire logic       i_chip_select_high,
	input  wire logic       i_chip_select_low_n,
	input  wire logic       i_ram_select_n,
	input  wire logic       i_read_not_write,
	input  wire logic [6:0] i_addr,
	input  wire logic [7:0] i_data,
	output logic      [7:0] o_data,
	output logic            o_data_oe,
	// Port A
	input  wire logic [7:0] i_port_a,
	output logic      [7:0] o_port_a,
	output logic      [7:0] o_port_a_oe,
	// Port B
	input  wire logic [7:0] i_port_b,
	output logic      [7:0] o_port_b,
	output logic      [7:0] o_port_b_oe,
	// Interrupt request, open drain
	output logic            o_irq_n,
	output logic            o_irq_oe
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic       chip_sel;
	logic       ram_sel;
	logic       io_sel;
	logic       port_sel;
	logic       func_sel;
	logic       rd;
	logic       timer_wr;
	logic       timer_rd;
	logic       timer_access;
	logic       flag_rd;
	logic       edge_cfg_wr;
	logic [7:0] ram [RAM_DEPTH];
	logic [7:0] port_a_output_reg;
	logic [7:0] port_a_direction_reg;
	logic [7:0] port_b_output_reg;
	logic [7:0] port_b_direction_reg;
	logic [7:0] timer_count;
	logic       timeout;
	logic       timer_irq_en;
	logic       timer_flag;
	logic       port_a_bit7_edge_input;
	logic       edge_prev;
	logic       edge_rise;
	logic       edge_fall;
	logic       edge_active;
	logic       edge_irq_en;
	logic       edge_pol;
	logic       edge_flag;
	logic [7:0] flag_value;
	logic [7:0] port_b_read;
	logic [7:0] next_read_data;
	logic       next_irq;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	// Every clock with the chip selected is one bus cycle
	assign rd           = i_read_not_write;
	assign chip_sel     = i_chip_select_high & ~i_chip_select_low_n;
	assign ram_sel      = chip_sel & ~i_ram_select_n; // R7
	assign io_sel       = chip_sel & i_ram_select_n; // R8
	assign port_sel     = io_sel & ~i_addr[ADDR_FUNC_BIT]; // R9
	assign func_sel     = io_sel & i_addr[ADDR_FUNC_BIT]; // R9
	assign timer_wr     = func_sel & ~rd & i_addr[ADDR_TMR_WR_BIT]; // R11
	assign edge_cfg_wr  = func_sel & ~rd & ~i_addr[ADDR_TMR_WR_BIT]; // R15
	assign timer_rd     = func_sel & rd & ~i_addr[ADDR_FLAG_RD_BIT];
	assign flag_rd      = func_sel & rd & i_addr[ADDR_FLAG_RD_BIT]; // R13
	assign timer_access = timer_wr | timer_rd;

	// ------------------------------------------------------------
	// RAM
	// ------------------------------------------------------------
	// Plain storage, left unreset as a real static RAM would be
	always_ff @(posedge i_sys_clk) begin
		if (ram_sel && !rd) begin
			ram[i_addr] <= i_data; // R7
		end
	end

	// ------------------------------------------------------------
	// Port registers
	// ------------------------------------------------------------
	// Reset zeroes all four, so every line starts as an input
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			port_a_output_reg    <= BYTE_ZERO;
			port_a_direction_reg <= BYTE_ZERO;
			port_b_output_reg    <= BYTE_ZERO;
			port_b_direction_reg <= BYTE_ZERO;
		end else if (port_sel && !rd) begin
			case (i_addr[1:0]) // R10
				PORT_A_OUT: port_a_output_reg    <= i_data;
				PORT_A_DIR: port_a_direction_reg <= i_data;
				PORT_B_OUT: port_b_output_reg    <= i_data;
				PORT_B_DIR: port_b_direction_reg <= i_data;
				default:    port_a_output_reg    <= port_a_output_reg;
			endcase
		end
	end

	// Direction bits drive the enables directly
	assign o_port_a    = port_a_output_reg;
	assign o_port_a_oe = port_a_direction_reg; // R22
	assign o_port_b    = port_b_output_reg;
	assign o_port_b_oe = port_b_direction_reg; // R22

	// Port B reads its own output register on output lines, so heavy
	// loads on a push-pull line cannot corrupt the value read back
	assign port_b_read = (port_b_output_reg & port_b_direction_reg)
		| (i_port_b & ~port_b_direction_reg);

	// ------------------------------------------------------------
	// Interval timer
	// ------------------------------------------------------------
	io_interval_timer u_timer (
		.i_sys_clk      (i_sys_clk),
		.i_rst_n        (i_rst_n),
		.i_load         (timer_wr), // R11
		.i_load_value   (i_data),
		.i_prescale_sel (i_addr[1:0]),
		.o_count        (timer_count),
		.o_timeout      (timeout)
	);

	// Timer IRQ enable follows bit 3 on every timer read or write
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			timer_irq_en <= 1'b0;
		end else if (timer_access) begin
			timer_irq_en <= i_addr[ADDR_IRQ_EN_BIT]; // R12
		end
	end

	// Timer flag: the set wins, so a read in the timeout clock keeps it
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			timer_flag <= 1'b0;
		end else if (timeout) begin
			timer_flag <= 1'b1; // R19 R2
		end else if (timer_access) begin
			timer_flag <= 1'b0; // R1
		end
	end

	// ------------------------------------------------------------
	// Edge sense on port A bit 7
	// ------------------------------------------------------------
	// Pin level is sensed whatever the direction register holds
	assign port_a_bit7_edge_input = i_port_a[EDGE_PIN_BIT]; // R16
	assign edge_rise   = port_a_bit7_edge_input & ~edge_prev;
	assign edge_fall   = ~port_a_bit7_edge_input & edge_prev;
	assign edge_active = edge_pol ? edge_rise : edge_fall;

	// Previous level keeps sampling through reset
	always_ff @(posedge i_sys_clk) begin
		edge_prev <= port_a_bit7_edge_input;
	end

	// Edge configuration; data lines are ignored
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			edge_irq_en <= 1'b0; // R17
			edge_pol    <= EDGE_POL_NEG; // R17
		end else if (edge_cfg_wr) begin
			edge_irq_en <= i_addr[ADDR_EDGE_IRQ_BIT]; // R15
			edge_pol    <= i_addr[ADDR_EDGE_POL_BIT]; // R15
		end
	end

	// Edge flag; a falling edge during reset may leave it set, which
	// software has to clear with a flag read before trusting it
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			edge_flag <= edge_fall; // R17
		end else if (edge_active) begin
			edge_flag <= 1'b1; // R14 R16
		end else if (flag_rd) begin
			edge_flag <= 1'b0; // R6
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Flag register image, unused bits read as zero
	always_comb begin
		flag_value                 = BYTE_ZERO;
		flag_value[FLAG_TIMER_BIT] = timer_flag; // R5
		flag_value[FLAG_EDGE_BIT]  = edge_flag; // R5
	end

	// Read data selection
	always_comb begin
		next_read_data = BYTE_ZERO;
		if (ram_sel) begin
			next_read_data = ram[i_addr];
		end else if (port_sel) begin
			case (i_addr[1:0]) // R10
				PORT_A_OUT: next_read_data = i_port_a;
				PORT_A_DIR: next_read_data = port_a_direction_reg;
				PORT_B_OUT: next_read_data = port_b_read;
				PORT_B_DIR: next_read_data = port_b_direction_reg;
				default:    next_read_data = BYTE_ZERO;
			endcase
		end else if (flag_rd) begin
			next_read_data = flag_value; // R13
		end else if (timer_rd) begin
			next_read_data = timer_count; // R3
		end
	end

	// Data bus driven only the clock after a selected read
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_data    <= BYTE_ZERO;
			o_data_oe <= 1'b0;
		end else begin
			o_data    <= next_read_data;
			o_data_oe <= rd & chip_sel;
		end
	end

	// ------------------------------------------------------------
	// Interrupt request
	// ------------------------------------------------------------
	assign next_irq = (timer_flag & timer_irq_en) | (edge_flag & edge_irq_en);

	// Open drain: the level is always low, only the enable moves
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_irq_n  <= 1'b0;
			o_irq_oe <= 1'b0;
		end else begin
			o_irq_n  <= 1'b0; // R21
			o_irq_oe <= next_irq; // R21 R14
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence ram_write_s;
		ram_sel && !rd;
	endsequence

	sequence ram_read_back_s;
		!ram_sel ##1 ram_sel && rd && i_addr == $past(i_addr, 2);
	endsequence

	sequence prescale8_load_s;
		timer_wr && i_addr[1:0] == PRESCALE_8 && i_data == COUNT_ONE;
	endsequence

	sequence no_reload3_s;
		(!timer_wr) [*8];
	endsequence

	ram_read_back_a: assert property ( // R7
		ram_write_s ##1 ram_read_back_s |=> o_data_oe && o_data == $past(i_data, 3))
		else $error("RAM read back differs from write");

	deselect_quiet_a: assert property ( // R8
		!chip_sel |=> !o_data_oe)
		else $error("Data bus driven while deselected");

	port_dir_write_a: assert property ( // R10
		port_sel && !rd && i_addr[1:0] == PORT_A_DIR
		|=> o_port_a_oe == $past(i_data) ##1 o_port_a_oe == $past(i_data, 2) || $past(port_sel))
		else $error("Port A direction not updated");

	timer_clear_a: assert property ( // R1
		timer_flag && timer_access && !timeout |=> !timer_flag)
		else $error("Timer flag not cleared by timer access");

	same_clock_read_a: assert property ( // R2
		timeout && timer_rd |=> timer_flag ##1 (timer_flag || $past(timer_access)))
		else $error("Timer flag lost on coincident read");

	flag_image_a: assert property ( // R13
		flag_rd |=> o_data_oe && o_data[FLAG_TIMER_BIT] == $past(timer_flag)
			&& o_data[FLAG_EDGE_BIT] == $past(edge_flag) && o_data[5:0] == 6'h00)
		else $error("Flag register read wrong");

	flag_read_clear_a: assert property ( // R6
		flag_rd && !edge_active && timer_flag |=> !edge_flag && timer_flag)
		else $error("Flag read clear wrong");

	edge_set_a: assert property ( // R14
		edge_active |=> edge_flag)
		else $error("Edge flag not set");

	edge_irq_a: assert property ( // R14
		edge_flag && edge_irq_en |=> o_irq_oe && !o_irq_n)
		else $error("Edge interrupt not driven");

	timer_irq_gate_a: assert property ( // R12
		timer_flag && !timer_irq_en && !(edge_flag && edge_irq_en) |=> !o_irq_oe)
		else $error("Disabled timer interrupt driven");

	timeout_count_a: assert property ( // R3
		timeout |-> timer_count == COUNT_AFTER_TIMEOUT)
		else $error("Count not all ones at timeout");

	fast_count_a: assert property ( // R20
		timeout && !timer_wr |=> timer_count == COUNT_AFTER_TIMEOUT - COUNT_ONE)
		else $error("Count not stepping each clock after timeout");

	timeout_flag_a: assert property ( // R19
		timeout && !timer_irq_en |=> timer_flag)
		else $error("Timeout did not set timer flag");

	prescale_a: assert property ( // R11
		prescale8_load_s ##1 no_reload3_s |=> timer_count == BYTE_ZERO)
		else $error("Divide by eight step wrong");

	edge_config_a: assert property ( // R15
		edge_cfg_wr |=> edge_irq_en == $past(i_addr[ADDR_EDGE_IRQ_BIT])
			&& edge_pol == $past(i_addr[ADDR_EDGE_POL_BIT]))
		else $error("Edge configuration not taken");

	reset_edge_a: assert property ( // R17
		@(posedge i_sys_clk) disable iff (1'b0)
		!i_rst_n |=> !edge_irq_en && edge_pol == EDGE_POL_NEG && !o_irq_oe)
		else $error("Reset left edge interrupt enabled");

endmodule

// [verilog/io_timer_pkg.sv]
package io_timer_pkg;

	// ------------------------------------------------------------
	// Storage geometry
	// ------------------------------------------------------------
	localparam int unsigned RAM_DEPTH  = 128;
	localparam int unsigned RAM_ADDR_W = 7;

	// ------------------------------------------------------------
	// Address bit positions inside the I/O and timer section
	// ------------------------------------------------------------
	localparam int unsigned ADDR_FUNC_BIT     = 2;
	localparam int unsigned ADDR_IRQ_EN_BIT   = 3;
	localparam int unsigned ADDR_TMR_WR_BIT   = 4;
	localparam int unsigned ADDR_EDGE_IRQ_BIT = 1;
	localparam int unsigned ADDR_EDGE_POL_BIT = 0;
	localparam int unsigned ADDR_FLAG_RD_BIT  = 0;

	// ------------------------------------------------------------
	// Flag register layout and edge pin
	// ------------------------------------------------------------
	localparam int unsigned FLAG_TIMER_BIT = 7;
	localparam int unsigned FLAG_EDGE_BIT  = 6;
	localparam int unsigned EDGE_PIN_BIT   = 7;

	// ------------------------------------------------------------
	// Port register selects on address bits 1:0
	// ------------------------------------------------------------
	localparam logic [1:0] PORT_A_OUT = 2'h0;
	localparam logic [1:0] PORT_A_DIR = 2'h1;
	localparam logic [1:0] PORT_B_OUT = 2'h2;
	localparam logic [1:0] PORT_B_DIR = 2'h3;

	// ------------------------------------------------------------
	// Prescale selects and divisors
	// ------------------------------------------------------------
	localparam logic [1:0]  PRESCALE_1    = 2'h0;
	localparam logic [1:0]  PRESCALE_8    = 2'h1;
	localparam logic [1:0]  PRESCALE_64   = 2'h2;
	localparam logic [1:0]  PRESCALE_1024 = 2'h3;
	localparam logic [10:0] DIV_1         = 11'h001;
	localparam logic [10:0] DIV_8         = 11'h008;
	localparam logic [10:0] DIV_64        = 11'h040;
	localparam logic [10:0] DIV_1024      = 11'h400;

	// ------------------------------------------------------------
	// Reset values and small constants
	// ------------------------------------------------------------
	localparam logic [7:0]  BYTE_ZERO           = 8'h00;
	localparam logic [7:0]  COUNT_ONE           = 8'h01;
	localparam logic [7:0]  COUNT_AFTER_TIMEOUT = 8'hff;
	localparam logic [10:0] PRE_ZERO            = 11'h000;
	localparam logic [10:0] PRE_ONE             = 11'h001;
	localparam logic        EDGE_POL_NEG        = 1'b0;

	// ------------------------------------------------------------
	// Timer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		TMR_IDLE,
		TMR_COUNTING,
		TMR_EXPIRED
	} timer_state_e;

endpackage

// [verilog/io_interval_timer.sv]
`timescale 1ns/1ps
module io_interval_timer
	import io_timer_pkg::*;
(
	// Clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_n,
	// Load request
	input  wire logic       i_load,
	input  wire logic [7:0] i_load_value,
	input  wire logic [1:0] i_prescale_sel,
	// Timer state
	output logic      [7:0] o_count,
	output logic            o_timeout
);

	timer_state_e state;
	logic [10:0]  divisor;
	logic [10:0]  pre_cnt;

	// Divisor captured at load so later address changes cannot disturb it
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			divisor <= DIV_1;
		end else if (i_load) begin
			case (i_prescale_sel)
				PRESCALE_1:    divisor <= DIV_1;
				PRESCALE_8:    divisor <= DIV_8;
				PRESCALE_64:   divisor <= DIV_64;
				PRESCALE_1024: divisor <= DIV_1024;
				default:       divisor <= DIV_1;
			endcase
		end
	end

	// Countdown; idle after reset so no spurious timeout before first load
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			state     <= TMR_IDLE;
			o_count   <= BYTE_ZERO;
			pre_cnt   <= PRE_ZERO;
			o_timeout <= 1'b0;
		end else begin
			o_timeout <= 1'b0;
			if (i_load) begin
				o_count <= i_load_value;
				pre_cnt <= PRE_ZERO;
				state   <= TMR_COUNTING;
			end else begin
				case (state)
					TMR_IDLE: begin
						pre_cnt <= PRE_ZERO;
					end
					TMR_COUNTING: begin
						if (o_count == BYTE_ZERO) begin
							o_count   <= COUNT_AFTER_TIMEOUT;
							state     <= TMR_EXPIRED;
							o_timeout <= 1'b1;
						end else if (pre_cnt == divisor - PRE_ONE) begin
							pre_cnt <= PRE_ZERO;
							o_count <= o_count - COUNT_ONE;
						end else begin
							pre_cnt <= pre_cnt + PRE_ONE;
						end
					end
					TMR_EXPIRED: begin
						o_count <= o_count - COUNT_ONE; // R20
					end
					default: begin
						state <= TMR_IDLE;
					end
				endcase
			end
		end
	end

endmodule

// [test/cpu_bus_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Processor side of the device bus
// ----------------------------------------
module cpu_bus_model (
	// Clock
	input  wire logic       i_sys_clk,
	// Bus toward the device
	output logic            o_cs_high,
	output logic            o_cs_low_n,
	output logic            o_ram_sel_n,
	output logic            o_rd,
	output logic [6:0]      o_addr,
	output logic [7:0]      o_wdata,
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_rdata_oe
);
	logic [7:0] last;

	// Idle bus starts deselected
	initial begin
		last = 8'h00;
		o_cs_high = 1'b0;
		o_cs_low_n = 1'b1;
		o_ram_sel_n = 1'b1;
		o_rd = 1'b1;
		o_addr = 7'h00;
		o_wdata = 8'hff;
	end

	// One access, held over one whole cycle and taken at its closing edge
	task automatic access(input logic cs_h, input logic cs_l_n, input logic rs_n,
		input logic rd, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge i_sys_clk);
		#1;
		o_cs_high = cs_h;
		o_cs_low_n = cs_l_n;
		o_ram_sel_n = rs_n;
		o_rd = rd;
		o_addr = a;
		o_wdata = d;
		@(posedge i_sys_clk);
		#1;
		// Undriven data bus shows the inverse of its last value, not a stale match
		q = i_rdata_oe ? i_rdata : ~last;
		last = q;
		o_cs_high = 1'b0;
		o_cs_low_n = 1'b1;
		o_addr = ~a;
		o_wdata = ~d;
	endtask
endmodule

// [test/io_timer_decode_and_irq_tb_top.sv]
`timescale 1ns/1ps
module io_timer_decode_and_irq_tb_top;
	import io_timer_pkg::*;
	logic       i_sys_clk;
	logic       i_rst_n;
	logic       cs_h;
	logic       cs_l_n;
	logic       rs_n;
	logic       rd_n_wr;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       rdata_oe;
	logic [7:0] pa_out;
	logic [7:0] pa_oe;
	logic [7:0] pb_out;
	logic [7:0] pb_oe;
	logic [7:0] pa_ext;
	logic [7:0] pb_ext;
	logic       irq_n;
	logic       irq_oe;
	logic [7:0] q;
	logic [7:0] q2;
	logic       outmode;
	int         err_count;
	int         check_count;
	int         div;
	int         k;

	// ----------------------------------------
	// Clock, pins and instances
	// ----------------------------------------
	always #2 i_sys_clk = ~i_sys_clk;

	// Port A pins follow the device where it drives, else the outside world
	wire [7:0] pa_pin = (pa_oe & pa_out) | (~pa_oe & pa_ext);

	cpu_bus_model u_cpu (.i_sys_clk(i_sys_clk), .o_cs_high(cs_h), .o_cs_low_n(cs_l_n),
		.o_ram_sel_n(rs_n), .o_rd(rd_n_wr), .o_addr(addr), .o_wdata(wdata),
		.i_rdata(rdata), .i_rdata_oe(rdata_oe));

	io_timer_decode_and_irq u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.i_chip_select_high(cs_h), .i_chip_select_low_n(cs_l_n), .i_ram_select_n(rs_n),
		.i_read_not_write(rd_n_wr), .i_addr(addr), .i_data(wdata), .o_data(rdata),
		.o_data_oe(rdata_oe), .i_port_a(pa_pin), .o_port_a(pa_out), .o_port_a_oe(pa_oe),
		.i_port_b(pb_ext), .o_port_b(pb_out), .o_port_b_oe(pb_oe), .o_irq_n(irq_n),
		.o_irq_oe(irq_oe));

	// ----------------------------------------
	// Bus tasks and compares
	// ----------------------------------------
	task automatic wr(input logic r, input logic [6:0] a, input logic [7:0] d);
		logic [7:0] dummy;
		u_cpu.access(1'b1, 1'b0, r, 1'b0, a, d, dummy);
	endtask

	task automatic rd(input logic r, input logic [6:0] a, output logic [7:0] d);
		u_cpu.access(1'b1, 1'b0, r, 1'b1, a, 8'h00, d);
	endtask

	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check1(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask

	// Edge source is either the outside pin or the port A output register
	task automatic set_pa7(input logic v);
		if (outmode) begin
			wr(1'b1, 7'h00, {v, 7'h00});
		end else begin
			@(posedge i_sys_clk);
			#1;
			pa_ext[7] = v;
		end
	endtask

	task automatic test_end(input string name);
		$display("Test %s finished", name);
	endtask

	task automatic test_done();
		$display("Checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Watchdog, well beyond the expected run
	// ----------------------------------------
	initial begin
		repeat (40000) @(posedge i_sys_clk);
		err_count++;
		test_done();
	end

	// Main sequence
	initial begin
		i_sys_clk = 1'b0;
		i_rst_n = 1'b0;
		pa_ext = 8'hbc;
		pb_ext = 8'h5c;
		outmode = 1'b0;
		err_count = 0;
		check_count = 0;
		cycles(8);
		i_rst_n = 1'b1;
		check8(pa_oe, 8'h00);
		check8(pb_oe, 8'h00);
		check1(irq_oe, 1'b0);
		test_end("reset");

		// Defaults: falling edge sets the flag, request stays off
		rd(1'b1, 7'h05, q);
		set_pa7(1'b0);
		cycles(3);
		check1(irq_oe, 1'b0);
		rd(1'b1, 7'h05, q);
		check8(q, 8'h40);
		set_pa7(1'b1);
		cycles(3);
		rd(1'b1, 7'h05, q);
		check8(q, 8'h00);
		test_end("edge_defaults");

		// All four edge modes, pin as input then as output
		for (int m = 0; m < 2; m++) begin
			outmode = m[0];
			wr(1'b1, 7'h01, {m[0], 7'h00});
			for (int c = 0; c < 4; c++) begin
				set_pa7(~c[0]);
				wr(1'b1, 7'h04 | 7'(c), 8'h5a);
				rd(1'b1, 7'h05, q);
				set_pa7(c[0]);
				cycles(3);
				check1(irq_oe, c[1]);
				rd(1'b1, 7'h05, q);
				check8(q, 8'h40);
				cycles(3);
				check1(irq_oe, 1'b0);
				set_pa7(~c[0]);
				cycles(3);
				rd(1'b1, 7'h05, q);
				check8(q, 8'h00);
			end
		end
		outmode = 1'b0;
		// Park edge sense on falling edge with request off, so port writes stay quiet
		wr(1'b1, 7'h04, 8'h00);
		rd(1'b1, 7'h05, q);
		test_end("edge_modes");

		// Port registers
		wr(1'b1, 7'h00, 8'ha5);
		wr(1'b1, 7'h01, 8'hf0);
		wr(1'b1, 7'h02, 8'h96);
		wr(1'b1, 7'h03, 8'h0f);
		check8(pa_oe, 8'hf0);
		check8(pb_out, 8'h96);
		check8(pb_oe, 8'h0f);
		rd(1'b1, 7'h00, q);
		check8(q, 8'ha0 | (pa_ext & 8'h0f));
		rd(1'b1, 7'h01, q);
		check8(q, 8'hf0);
		rd(1'b1, 7'h02, q);
		check8(q, 8'h06 | (pb_ext & 8'hf0));
		rd(1'b1, 7'h03, q);
		check8(q, 8'h0f);
		test_end("ports");

		// RAM decode and deselected cycles
		wr(1'b0, 7'h7f, 8'h5a);
		rd(1'b0, 7'h7f, q);
		check8(q, 8'h5a);
		wr(1'b0, 7'h01, 8'hc3);
		check8(pa_oe, 8'hf0);
		u_cpu.access(1'b0, 1'b0, 1'b0, 1'b0, 7'h7f, 8'h00, q);
		u_cpu.access(1'b1, 1'b1, 1'b0, 1'b0, 7'h7f, 8'h00, q);
		u_cpu.access(1'b0, 1'b0, 1'b1, 1'b0, 7'h01, 8'h00, q);
		check8(pa_oe, 8'hf0);
		u_cpu.access(1'b1, 1'b1, 1'b0, 1'b1, 7'h7f, 8'h00, q);
		check1(rdata_oe, 1'b0);
		rd(1'b0, 7'h7f, q);
		check8(q, 8'h5a);
		rd(1'b0, 7'h01, q);
		check8(q, 8'hc3);
		test_end("ram");

		// Each prescale, request enabled, then post-timeout countdown
		for (int s = 0; s < 4; s++) begin
			div = (s == 3) ? 1024 : 1 << (3 * s);
			wr(1'b1, 7'h1c | 7'(s), 8'h01);
			cycles(div - 1);
			check1(irq_oe, 1'b0);
			for (k = 0; k < 8 && irq_oe !== 1'b1; k++) cycles(1);
			check1(irq_oe, 1'b1);
			check1(irq_n, 1'b0);
			rd(1'b1, 7'h04, q);
			rd(1'b1, 7'h04, q2);
			check8(q, 8'hfc);
			check8(q2, q - 8'h02);
			cycles(2);
			check1(irq_oe, 1'b0);
			rd(1'b1, 7'h05, q);
			check8(q, 8'h00);
		end
		test_end("prescale");

		// Flag set with the request disabled; read with bit 3 high clears it
		wr(1'b1, 7'h14, 8'h01);
		cycles(8);
		check1(irq_oe, 1'b0);
		rd(1'b1, 7'h05, q);
		check8(q, 8'h80);
		rd(1'b1, 7'h0c, q);
		cycles(3);
		check1(irq_oe, 1'b0);
		rd(1'b1, 7'h05, q);
		check8(q, 8'h00);

		// Read landing on the timeout clock keeps the flag
		wr(1'b1, 7'h14, 8'h01);
		cycles(1);
		rd(1'b1, 7'h04, q);
		check8(q, 8'hff);
		rd(1'b1, 7'h05, q);
		check8(q, 8'h80);
		rd(1'b1, 7'h04, q);

		// Slow prescale holds the loaded count
		wr(1'b1, 7'h17, 8'h03);
		rd(1'b1, 7'h04, q);
		check8(q, 8'h03);
		rd(1'b1, 7'h04, q);
		check8(q, 8'h03);
		test_end("timer_flag");
		test_done();
	end
endmodule
